// *** mac_dp_pkg.sv ***
// Constants, types and register map of the multiply-accumulate and dual pointer unit
package mac_dp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_PTR0_LO   = 8'h82;
   localparam logic [7:0] IDX_PTR0_HI   = 8'h83;
   localparam logic [7:0] IDX_PTR1_LO   = 8'h84;
   localparam logic [7:0] IDX_PTR1_HI   = 8'h85;
   localparam logic [7:0] IDX_PTR_CFG   = 8'ha2;
   localparam logic [7:0] IDX_FLAGS     = 8'hd0;
   localparam logic [7:0] IDX_ACC       = 8'he0;
   localparam logic [7:0] IDX_OPA_HI    = 8'he1;
   localparam logic [7:0] IDX_DSP_CFG   = 8'he2;
   localparam logic [7:0] IDX_WIN_LO    = 8'he4;
   localparam logic [7:0] IDX_WIN_HI    = 8'he5;
   localparam logic [7:0] IDX_B         = 8'hf0;
   localparam logic [7:0] IDX_OPB_HI    = 8'hf7;
   localparam logic [7:0] IDX_COMMAND   = 8'h01;
   localparam logic [7:0] IDX_STATUS    = 8'h02;
   localparam logic [7:0] IDX_FETCHED   = 8'h03;
   // Field positions
   localparam int BIT_REDIRECT  = 0;
   localparam int BIT_NO_INDEX  = 1;
   localparam int BIT_CIRC0     = 2;
   localparam int BIT_CIRC1     = 3;
   localparam int BIT_SIGN_A    = 4;
   localparam int BIT_SIGN_B    = 5;
   localparam int BIT_WIN_LSB   = 6;
   localparam int BIT_SELECT    = 0;
   localparam int BIT_CARRY     = 7;
   localparam int BIT_OVF       = 2;
   // Reset values and read masks
   localparam logic [7:0] DSP_CFG_RESET = 8'h00;
   localparam logic [7:0] PTR_CFG_RESET = 8'h00;
   localparam logic [7:0] PTR_CFG_MASK  = 8'hf9;
   // Opcodes
   localparam logic [7:0] OP_PREFIX  = 8'ha5;
   localparam logic [7:0] OP_MAC     = 8'ha4;
   localparam logic [7:0] OP_CLEAR   = 8'he4;
   localparam logic [7:0] OP_SHL     = 8'h23;
   localparam logic [7:0] OP_ASR     = 8'h03;
   localparam logic [7:0] OP_MUL     = 8'ha4;
   localparam logic [7:0] OP_INC_PTR = 8'ha3;
   localparam logic [7:0] OP_JMP_IND = 8'h73;
   localparam logic [7:0] OP_MOVC    = 8'h93;
   localparam logic [7:0] OP_MOVX_RD = 8'he0;
   localparam logic [7:0] OP_MOVX_WR = 8'hf0;
   localparam logic [7:0] OP_MOV_PTR = 8'h90;
   // Cycle counts
   localparam logic [3:0] CYC_MAC   = 4'h9;
   localparam logic [3:0] CYC_CLEAR = 4'h2;
   localparam logic [3:0] CYC_SHIFT = 4'h2;
   localparam logic [3:0] CYC_MUL   = 4'h2;

   typedef enum logic {ST_IDLE, ST_EXEC} exec_state_e;

   // Command word: software issues one instruction at a time
   typedef struct packed {
      logic       branch;
      logic [1:0] length;
      logic       prefix;
      logic [7:0] opcode;
   } instr_s;
endpackage

// *** mac_arith.sv ***
// Multiply-accumulate and byte multiply arithmetic
`timescale 1ns/1ps
module mac_arith (
   input  wire logic [39:0] accum_i,
   input  wire logic [15:0] opa_i,
   input  wire logic [15:0] opb_i,
   input  wire logic        sign_a_i,
   input  wire logic        sign_b_i,
   output logic      [39:0] sum_o,
   output logic             ovf_o,
   output logic      [15:0] byte_prod_o
);
   logic signed [31:0] prod;
   logic signed [39:0] prod_ext;
   logic signed [17:0] byte_prod;
   logic signed [8:0]  ea;
   logic signed [8:0]  eb;

   assign prod     = $signed(opa_i) * $signed(opb_i);
   assign prod_ext = 40'(prod);
   assign sum_o    = accum_i + prod_ext;
   // Overflow when both addends agree in sign and the sum does not
   assign ovf_o    = (accum_i[39] == prod_ext[39]) && (sum_o[39] != accum_i[39]);
   assign ea       = {sign_a_i & opa_i[7], opa_i[7:0]};
   assign eb       = {sign_b_i & opb_i[7], opb_i[7:0]};
   assign byte_prod   = ea * eb;
   assign byte_prod_o = byte_prod[15:0];
endmodule // mac_arith

// *** mac_and_dual_pointer_unit.sv ***
// Multiply-accumulate unit and dual data pointers behind an APB slave
`timescale 1ns/1ps
module mac_and_dual_pointer_unit (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   output logic             busy_o,
   output logic             ptr_one_active_o,
   output logic             circular_active_o,
   output logic             data_reg_is_b_o,
   output logic      [15:0] code_addr_o
);
   logic [39:0]                m_reg;
   logic [7:0]                 acc_reg;
   logic [7:0]                 b_reg;
   logic [7:0]                 opa_hi_reg;
   logic [7:0]                 opb_hi_reg;
   logic [7:0]                 dsp_reg;
   logic [7:0]                 ptr_cfg_reg;
   logic [15:0]                ptr0_reg;
   logic [15:0]                ptr1_reg;
   logic                       carry_reg;
   logic                       ovf_reg;
   mac_dp_pkg::instr_s         cmd_reg;
   mac_dp_pkg::exec_state_e    state_reg;
   logic [3:0]                 count_reg;
   logic [1:0]                 fetch_left_reg;
   logic [15:0]                fetched_reg;
   logic [31:0]                rd_data;

   // Bus decode
   wire        access    = psel_i & penable_i;
   wire        done_bus  = access & pready_o;
   wire        wr_en     = done_bus & pwrite_i;
   wire [7:0]  idx       = paddr_i[9:2];
   wire        aligned   = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0);
   wire [7:0]  wbyte     = pwdata_i[7:0];
   function automatic logic wr_to(input logic [7:0] target);
      wr_to = wr_en && aligned && (idx == target);
   endfunction
   wire        hit = aligned && (idx == mac_dp_pkg::IDX_PTR0_LO || idx == mac_dp_pkg::IDX_PTR0_HI ||
                                 idx == mac_dp_pkg::IDX_PTR1_LO || idx == mac_dp_pkg::IDX_PTR1_HI ||
                                 idx == mac_dp_pkg::IDX_PTR_CFG || idx == mac_dp_pkg::IDX_FLAGS ||
                                 idx == mac_dp_pkg::IDX_ACC || idx == mac_dp_pkg::IDX_OPA_HI ||
                                 idx == mac_dp_pkg::IDX_DSP_CFG || idx == mac_dp_pkg::IDX_WIN_LO ||
                                 idx == mac_dp_pkg::IDX_WIN_HI || idx == mac_dp_pkg::IDX_B ||
                                 idx == mac_dp_pkg::IDX_OPB_HI || idx == mac_dp_pkg::IDX_COMMAND ||
                                 idx == mac_dp_pkg::IDX_STATUS || idx == mac_dp_pkg::IDX_FETCHED);

   // Window field
   wire [1:0]  win_sel = dsp_reg[mac_dp_pkg::BIT_WIN_LSB +: 2];
   wire [5:0]  win_lsb = {1'b0, win_sel, 3'h0};
   wire [15:0] win_val = m_reg[win_lsb +: 16];

   // Instruction issue and decode
   mac_dp_pkg::instr_s new_cmd;
   assign new_cmd = pwdata_i[11:0];
   wire issue   = wr_to(mac_dp_pkg::IDX_COMMAND) && (state_reg == mac_dp_pkg::ST_IDLE);
   wire n_ext   = new_cmd.prefix;
   wire n_mac   = n_ext && new_cmd.opcode == mac_dp_pkg::OP_MAC;
   wire n_clr   = n_ext && new_cmd.opcode == mac_dp_pkg::OP_CLEAR;
   wire n_shift = n_ext && (new_cmd.opcode == mac_dp_pkg::OP_SHL || new_cmd.opcode == mac_dp_pkg::OP_ASR);
   wire n_mul   = !n_ext && new_cmd.opcode == mac_dp_pkg::OP_MUL;
   wire n_len0  = new_cmd.length == 2'h0;
   wire [3:0] n_plain = {2'h0, n_len0 ? 2'h1 : new_cmd.length} + {3'h0, new_cmd.branch};
   wire [3:0] n_cycles = n_mac   ? mac_dp_pkg::CYC_MAC :
                         n_clr   ? mac_dp_pkg::CYC_CLEAR :
                         n_shift ? mac_dp_pkg::CYC_SHIFT :
                         n_mul   ? mac_dp_pkg::CYC_MUL : n_plain;
   // Prefix inverts the select, except for the indirect jump
   wire n_inverted = new_cmd.prefix && new_cmd.opcode != mac_dp_pkg::OP_JMP_IND;
   wire n_use_p1   = ptr_cfg_reg[mac_dp_pkg::BIT_SELECT] ^ n_inverted;
   wire [15:0] n_ptr = n_use_p1 ? ptr1_reg : ptr0_reg;
   wire n_movc   = new_cmd.opcode == mac_dp_pkg::OP_MOVC;
   wire n_movx   = new_cmd.opcode == mac_dp_pkg::OP_MOVX_RD || new_cmd.opcode == mac_dp_pkg::OP_MOVX_WR;
   wire n_no_idx = dsp_reg[mac_dp_pkg::BIT_NO_INDEX];
   wire [15:0] n_addr = (n_movc && !n_no_idx) ? n_ptr + {8'h00, acc_reg} : n_ptr;
   wire n_to_b   = (n_movc || n_movx) && n_use_p1 && dsp_reg[mac_dp_pkg::BIT_REDIRECT];
   wire n_circ   = n_use_p1 ? dsp_reg[mac_dp_pkg::BIT_CIRC1] : dsp_reg[mac_dp_pkg::BIT_CIRC0];

   // Completion of the running instruction
   wire ex_done  = (state_reg == mac_dp_pkg::ST_EXEC) && (count_reg == 4'h1);
   wire c_ext    = cmd_reg.prefix;
   wire do_mac   = ex_done && c_ext && cmd_reg.opcode == mac_dp_pkg::OP_MAC;
   wire do_clr   = ex_done && c_ext && cmd_reg.opcode == mac_dp_pkg::OP_CLEAR;
   wire do_shl   = ex_done && c_ext && cmd_reg.opcode == mac_dp_pkg::OP_SHL;
   wire do_asr   = ex_done && c_ext && cmd_reg.opcode == mac_dp_pkg::OP_ASR;
   wire do_mul   = ex_done && !c_ext && cmd_reg.opcode == mac_dp_pkg::OP_MUL;
   wire c_inv    = c_ext && cmd_reg.opcode != mac_dp_pkg::OP_JMP_IND;
   wire c_use_p1 = ptr_one_active_o;
   wire do_inc0  = ex_done && cmd_reg.opcode == mac_dp_pkg::OP_INC_PTR && !c_use_p1 && (c_inv || !c_ext);
   wire do_inc1  = ex_done && cmd_reg.opcode == mac_dp_pkg::OP_INC_PTR && c_use_p1 && (c_inv || !c_ext);

   // Arithmetic
   wire [39:0] mac_sum;
   wire        mac_ovf;
   wire [15:0] mul_prod;
   mac_arith mac_arith_i (
      .accum_i     (m_reg),
      .opa_i       ({opa_hi_reg, acc_reg}),
      .opb_i       ({opb_hi_reg, b_reg}),
      .sign_a_i    (dsp_reg[mac_dp_pkg::BIT_SIGN_A]),
      .sign_b_i    (dsp_reg[mac_dp_pkg::BIT_SIGN_B]),
      .sum_o       (mac_sum),
      .ovf_o       (mac_ovf),
      .byte_prod_o (mul_prod)
   );

   // Accumulator next value: software window write, then instruction result
   logic [39:0] m_win;
   always_comb begin
      m_win = m_reg;
      if (wr_to(mac_dp_pkg::IDX_WIN_LO)) begin
         m_win[win_lsb +: 8] = wbyte;
      end
      if (wr_to(mac_dp_pkg::IDX_WIN_HI)) begin
         m_win[(win_lsb + 6'd8) +: 8] = wbyte;
      end
   end
   // Instruction result beats a window write in the same cycle
   wire [39:0] m_next = do_mac ? mac_sum :
                        do_clr ? 40'h00_0000_0000 :
                        do_shl ? {m_reg[38:0], 1'b0} :
                        do_asr ? {m_reg[39], m_reg[39:1]} :
                        m_win;

   // Read mux
   always_comb begin
      rd_data = 32'h0000_0000;
      case (idx)
         mac_dp_pkg::IDX_PTR0_LO: rd_data[7:0]  = ptr0_reg[7:0];
         mac_dp_pkg::IDX_PTR0_HI: rd_data[7:0]  = ptr0_reg[15:8];
         mac_dp_pkg::IDX_PTR1_LO: rd_data[7:0]  = ptr1_reg[7:0];
         mac_dp_pkg::IDX_PTR1_HI: rd_data[7:0]  = ptr1_reg[15:8];
         mac_dp_pkg::IDX_PTR_CFG: rd_data[7:0]  = ptr_cfg_reg & mac_dp_pkg::PTR_CFG_MASK;
         mac_dp_pkg::IDX_FLAGS: begin
            rd_data[mac_dp_pkg::BIT_CARRY] = carry_reg;
            rd_data[mac_dp_pkg::BIT_OVF]   = ovf_reg;
         end
         mac_dp_pkg::IDX_ACC:     rd_data[7:0]  = acc_reg;
         mac_dp_pkg::IDX_OPA_HI:  rd_data[7:0]  = opa_hi_reg;
         mac_dp_pkg::IDX_DSP_CFG: rd_data[7:0]  = dsp_reg;
         mac_dp_pkg::IDX_WIN_LO:  rd_data[7:0]  = win_val[7:0];
         mac_dp_pkg::IDX_WIN_HI:  rd_data[7:0]  = win_val[15:8];
         mac_dp_pkg::IDX_B:       rd_data[7:0]  = b_reg;
         mac_dp_pkg::IDX_OPB_HI:  rd_data[7:0]  = opb_hi_reg;
         mac_dp_pkg::IDX_COMMAND: rd_data[11:0] = cmd_reg;
         mac_dp_pkg::IDX_STATUS:  rd_data[7:0]  = {4'h0, count_reg};
         mac_dp_pkg::IDX_FETCHED: rd_data[15:0] = fetched_reg;
         default:                 rd_data       = 32'h0000_0000;
      endcase
      if (!aligned) begin
         rd_data = 32'h0000_0000;
      end
   end

   // Bus response: one wait state, data and error registered
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= access & ~pready_o;
         prdata_o  <= (access & ~pready_o & ~pwrite_i) ? rd_data : 32'h0000_0000;
         pslverr_o <= access & ~pready_o & ~hit;
      end
   end

   // Accumulator
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         m_reg <= 40'h00_0000_0000;
      end else begin
         m_reg <= m_next;
      end
   end

   // Operand and configuration registers; multiply is the only writer besides software
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         acc_reg     <= 8'h00;
         b_reg       <= 8'h00;
         opa_hi_reg  <= 8'h00;
         opb_hi_reg  <= 8'h00;
         dsp_reg     <= mac_dp_pkg::DSP_CFG_RESET;
         ptr_cfg_reg <= mac_dp_pkg::PTR_CFG_RESET;
      end else begin
         if (do_mul) begin
            acc_reg <= mul_prod[7:0];
            b_reg   <= mul_prod[15:8];
         end else begin
            if (wr_to(mac_dp_pkg::IDX_ACC)) acc_reg <= wbyte;
            if (wr_to(mac_dp_pkg::IDX_B)) b_reg <= wbyte;
         end
         if (wr_to(mac_dp_pkg::IDX_OPA_HI)) opa_hi_reg <= wbyte;
         if (wr_to(mac_dp_pkg::IDX_OPB_HI)) opb_hi_reg <= wbyte;
         if (wr_to(mac_dp_pkg::IDX_DSP_CFG)) dsp_reg <= wbyte;
         if (wr_to(mac_dp_pkg::IDX_PTR_CFG)) ptr_cfg_reg <= wbyte & mac_dp_pkg::PTR_CFG_MASK;
      end
   end

   // Pointers: direct access whatever the select; increment wins over a write
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ptr0_reg <= 16'h0000;
         ptr1_reg <= 16'h0000;
      end else begin
         if (do_inc0) begin
            ptr0_reg <= ptr0_reg + 16'h0001;
         end else begin
            if (wr_to(mac_dp_pkg::IDX_PTR0_LO)) ptr0_reg[7:0] <= wbyte;
            if (wr_to(mac_dp_pkg::IDX_PTR0_HI)) ptr0_reg[15:8] <= wbyte;
         end
         if (do_inc1) begin
            ptr1_reg <= ptr1_reg + 16'h0001;
         end else begin
            if (wr_to(mac_dp_pkg::IDX_PTR1_LO)) ptr1_reg[7:0] <= wbyte;
            if (wr_to(mac_dp_pkg::IDX_PTR1_HI)) ptr1_reg[15:8] <= wbyte;
         end
      end
   end

   // Flags: accumulate sets carry to the sign; overflow set wins over a clear
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         carry_reg <= 1'b0;
         ovf_reg   <= 1'b0;
      end else if (do_mac) begin
         carry_reg <= mac_sum[39];
         ovf_reg   <= ovf_reg | mac_ovf;
      end else if (wr_to(mac_dp_pkg::IDX_FLAGS)) begin
         carry_reg <= wbyte[mac_dp_pkg::BIT_CARRY];
         ovf_reg   <= wbyte[mac_dp_pkg::BIT_OVF];
      end
   end

   // Sequencer; commands written while busy are dropped
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= mac_dp_pkg::ST_IDLE;
         count_reg <= 4'h0;
         cmd_reg   <= '0;
         busy_o    <= 1'b0;
      end else begin
         case (state_reg)
            mac_dp_pkg::ST_IDLE: begin
               if (issue) begin
                  state_reg <= mac_dp_pkg::ST_EXEC;
                  count_reg <= n_cycles;
                  cmd_reg   <= new_cmd;
                  busy_o    <= 1'b1;
               end
            end
            mac_dp_pkg::ST_EXEC: begin
               count_reg <= count_reg - 4'h1;
               if (ex_done) begin
                  state_reg <= mac_dp_pkg::ST_IDLE;
                  busy_o    <= 1'b0;
               end
            end
            default: begin
               state_reg <= mac_dp_pkg::ST_IDLE;
               busy_o    <= 1'b0;
            end
         endcase
      end
   end

   // Byte fetch: one byte per clock, overlapping execution of the current instruction
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         fetch_left_reg <= 2'h0;
         fetched_reg    <= 16'h0000;
      end else if (issue) begin
         fetch_left_reg <= n_len0 ? 2'h1 : new_cmd.length;
      end else if (fetch_left_reg != 2'h0) begin
         fetch_left_reg <= fetch_left_reg - 2'h1;
         fetched_reg    <= fetched_reg + 16'h0001;
      end
   end

   // Pointer side effects captured at issue
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ptr_one_active_o  <= 1'b0;
         circular_active_o <= 1'b0;
         data_reg_is_b_o   <= 1'b0;
         code_addr_o       <= 16'h0000;
      end else if (issue) begin
         ptr_one_active_o  <= n_use_p1;
         circular_active_o <= n_circ;
         data_reg_is_b_o   <= n_to_b;
         code_addr_o       <= n_addr;
      end
   end

   // Checks
   mac_nine_a: assert property (@(posedge clk_i) disable iff (reset_i)
      issue && n_mac |=> busy_o [*8] ##1 busy_o ##1 !busy_o)
      else $error("accumulate not nine cycles");
   clear_two_a: assert property (@(posedge clk_i) disable iff (reset_i)
      issue && n_clr |-> ##3 m_reg == 40'h00_0000_0000)
      else $error("clear did not zero accumulator");
   carry_sign_a: assert property (@(posedge clk_i) disable iff (reset_i)
      do_mac |=> carry_reg == m_reg[39])
      else $error("carry not result sign");
   ovf_sticky_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ovf_reg && do_mac |=> ovf_reg)
      else $error("overflow cleared by accumulate");
   asr_sign_a: assert property (@(posedge clk_i) disable iff (reset_i)
      do_asr |=> m_reg[39] == $past(m_reg[39]) && m_reg[38:0] == $past(m_reg[39:1]))
      else $error("arithmetic shift wrong");
   cfg_bit2_a: assert property (@(posedge clk_i) disable iff (reset_i)
      pready_o && aligned && idx == mac_dp_pkg::IDX_PTR_CFG |-> !prdata_o[2])
      else $error("pointer config bit 2 not zero");
   prefix_inv_a: assert property (@(posedge clk_i) disable iff (reset_i)
      issue && n_inverted |=> ptr_one_active_o != ptr_cfg_reg[mac_dp_pkg::BIT_SELECT])
      else $error("prefix did not invert select");
   jump_ignore_a: assert property (@(posedge clk_i) disable iff (reset_i)
      issue && new_cmd.opcode == mac_dp_pkg::OP_JMP_IND |=> ptr_one_active_o == ptr_cfg_reg[0])
      else $error("indirect jump used prefix");
   no_index_a: assert property (@(posedge clk_i) disable iff (reset_i)
      issue && n_movc && n_no_idx |=> code_addr_o == (ptr_one_active_o ? ptr1_reg : ptr0_reg))
      else $error("index not disabled");
   fetch_rate_a: assert property (@(posedge clk_i) disable iff (reset_i)
      fetch_left_reg != 2'h0 && !issue |=> fetched_reg == $past(fetched_reg) + 16'h0001)
      else $error("fetch not one byte per cycle");
   mac_cover: cover property (@(posedge clk_i) disable iff (reset_i) do_mac && mac_ovf);
   redirect_cover: cover property (@(posedge clk_i) disable iff (reset_i) issue && n_to_b);
   window_cover: cover property (@(posedge clk_i) disable iff (reset_i) wr_to(mac_dp_pkg::IDX_WIN_HI) && win_sel == 2'h3);
endmodule // mac_and_dual_pointer_unit

// *** core_bus_model.sv ***
// Register-bus master standing in for the core's decoder side
`timescale 1ns/1ps
module core_bus_model (
   input  wire logic        clk_i,
   input  wire logic [31:0] prdata_i,
   input  wire logic        pready_i,
   input  wire logic        pslverr_i,
   output logic             psel_o,
   output logic             penable_o,
   output logic             pwrite_o,
   output logic      [11:0] paddr_o,
   output logic      [31:0] pwdata_o
);
   initial begin
      psel_o = 1'b0;
      penable_o = 1'b0;
      pwrite_o = 1'b0;
      paddr_o = 12'h000;
      pwdata_o = 32'h0;
   end
   // Held until pready is seen; answer taken at that same edge
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
      @(posedge clk_i);
      psel_o <= 1'b1;
      pwrite_o <= w;
      paddr_o <= {2'b00, idx, 2'b00};
      pwdata_o <= wd;
      @(posedge clk_i);
      penable_o <= 1'b1;
      do @(posedge clk_i); while (pready_i !== 1'b1);
      rd = prdata_i;
      err = pslverr_i;
      psel_o <= 1'b0;
      penable_o <= 1'b0;
      // Stale data must not look valid after release
      pwdata_o <= ~wd;
   endtask
endmodule // core_bus_model

// *** test_mac_and_dual_pointer_unit.sv ***
// Directed register-bus tests of the accumulate unit and pointers
`timescale 1ns/1ps
module test_mac_and_dual_pointer_unit;
   localparam logic [7:0] ACC = mac_dp_pkg::IDX_ACC, BR = mac_dp_pkg::IDX_B, DSP = mac_dp_pkg::IDX_DSP_CFG;
   localparam logic [7:0] OPA = mac_dp_pkg::IDX_OPA_HI, OPB = mac_dp_pkg::IDX_OPB_HI, PCF = mac_dp_pkg::IDX_PTR_CFG;
   logic                  clk_i, reset_i, psel, pen, pwr, prdy, perr, busy, p1, circ, isb, err;
   logic           [11:0] paddr;
   logic           [15:0] caddr;
   logic           [31:0] pwd, prd, rdv;
   logic signed    [39:0] m;
   int                    error_cnt = 0, total_checks = 0;
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   mac_and_dual_pointer_unit mac_and_dual_pointer_unit_i (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy),
      .pslverr_o(perr), .busy_o(busy), .ptr_one_active_o(p1), .circular_active_o(circ),
      .data_reg_is_b_o(isb), .code_addr_o(caddr));
   core_bus_model core_bus_model_i (.clk_i(clk_i), .prdata_i(prd), .pready_i(prdy), .pslverr_i(perr),
      .psel_o(psel), .penable_o(pen), .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwd));
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      core_bus_model_i.xfer(1'b1, idx, {24'h0, d}, rdv, err);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [7:0] e);
      core_bus_model_i.xfer(1'b0, idx, 32'h0, rdv, err);
      chk({8'h0, rdv}, {32'h0, e});
   endtask
   // Counts busy cycles over a span longer than any instruction
   task automatic issue(input mac_dp_pkg::instr_s c, input logic [3:0] n);
      logic [3:0] cnt;
      cnt = 4'h0;
      core_bus_model_i.xfer(1'b1, mac_dp_pkg::IDX_COMMAND, {20'h0, c}, rdv, err);
      repeat (16) begin
         @(posedge clk_i);
         cnt += {3'b000, busy};
      end
      chk({36'h0, cnt}, {36'h0, n});
   endtask
   task automatic chk_m(input logic [39:0] v);
      for (int w = 0; w < 4; w++) begin
         wr(DSP, 8'(w << 6));
         rd(mac_dp_pkg::IDX_WIN_LO, v[8*w +: 8]);
         rd(mac_dp_pkg::IDX_WIN_HI, v[8*w+8 +: 8]);
      end
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      complete_run();
   end
   initial begin
      reset_i = 1'b1;
      repeat (3) @(posedge clk_i);
      reset_i <= 1'b0;
      rd(DSP, mac_dp_pkg::DSP_CFG_RESET);
      rd(PCF, 8'h00);
      for (int i = 0; i < 4; i++)
         wr(8'(mac_dp_pkg::IDX_PTR0_LO + i), 8'(8'h11 * (i + 1)));
      wr(PCF, 8'hff);
      rd(PCF, 8'hf9);
      for (int i = 0; i < 4; i++)
         rd(8'(mac_dp_pkg::IDX_PTR0_LO + i), 8'(8'h11 * (i + 1)));
      wr(ACC, 8'h34);
      for (int s = 0; s < 2; s++) begin
         wr(PCF, 8'(s));
         for (int p = 0; p < 2; p++) begin
            issue('{1'b0, 2'd1, p[0], mac_dp_pkg::OP_MOVX_RD}, 4'd1);
            chk({23'h0, p1, caddr}, {23'h0, s[0] ^ p[0], (s[0] ^ p[0]) ? 16'h4433 : 16'h2211});
         end
      end
      issue('{1'b0, 2'd1, 1'b1, mac_dp_pkg::OP_JMP_IND}, 4'd1);
      chk({39'h0, p1}, 40'h1);
      wr(DSP, 8'h09);
      issue('{1'b0, 2'd1, 1'b0, mac_dp_pkg::OP_MOVC}, 4'd1);
      chk({22'h0, isb, circ, caddr}, {22'h0, 2'b11, 16'h4467});
      wr(DSP, 8'h03);
      issue('{1'b0, 2'd1, 1'b1, mac_dp_pkg::OP_MOVC}, 4'd1);
      chk({22'h0, isb, circ, caddr}, {22'h0, 2'b00, 16'h2211});
      // Select is 1 here, so the prefixed increment must step pointer zero only
      issue('{1'b0, 2'd1, 1'b1, mac_dp_pkg::OP_INC_PTR}, 4'd1);
      rd(mac_dp_pkg::IDX_PTR0_LO, 8'h12);
      rd(mac_dp_pkg::IDX_PTR1_LO, 8'h33);
      issue('{1'b0, 2'd3, 1'b0, 8'h00}, 4'd3);
      issue('{1'b1, 2'd2, 1'b0, 8'h12}, 4'd3);
      for (int sa = 0; sa < 2; sa++) begin
         wr(ACC, 8'hff);
         wr(BR, 8'h02);
         wr(DSP, 8'(sa << 4));
         issue('{1'b0, 2'd1, 1'b0, mac_dp_pkg::OP_MUL}, 4'd2);
         rd(ACC, 8'hfe);
         rd(BR, sa ? 8'hff : 8'h01);
      end
      // Signed b only: 3 times -1; unsigned b would leave 02 in the high byte
      wr(ACC, 8'h03);
      wr(BR, 8'hff);
      wr(DSP, 8'h20);
      issue('{1'b0, 2'd1, 1'b0, mac_dp_pkg::OP_MUL}, 4'd2);
      rd(ACC, 8'hfd);
      rd(BR, 8'hff);
      wr(ACC, 8'h34);
      wr(OPA, 8'h12);
      wr(BR, 8'h10);
      wr(OPB, 8'hfe);
      issue('{1'b0, 2'd2, 1'b1, mac_dp_pkg::OP_CLEAR}, 4'd2);
      repeat (2)
         issue('{1'b0, 2'd2, 1'b1, mac_dp_pkg::OP_MAC}, 4'd9);
      m = 40'sd2 * ($signed(16'h1234) * $signed(16'hfe10));
      chk_m(m);
      rd(ACC, 8'h34);
      rd(OPA, 8'h12);
      rd(BR, 8'h10);
      rd(OPB, 8'hfe);
      rd(mac_dp_pkg::IDX_FLAGS, {m[39], 7'h0});
      issue('{1'b0, 2'd2, 1'b1, mac_dp_pkg::OP_SHL}, 4'd2);
      chk_m(m <<< 1);
      repeat (2)
         issue('{1'b0, 2'd2, 1'b1, mac_dp_pkg::OP_ASR}, 4'd2);
      chk_m(m >>> 1);
      // Largest positive value, then a positive product forces overflow
      for (int w = 0; w < 4; w += 2) begin
         wr(DSP, 8'(w << 6));
         wr(mac_dp_pkg::IDX_WIN_LO, 8'hff);
         wr(mac_dp_pkg::IDX_WIN_HI, 8'hff);
      end
      wr(DSP, 8'hc0);
      wr(mac_dp_pkg::IDX_WIN_HI, 8'h7f);
      wr(OPB, 8'h00);
      issue('{1'b0, 2'd2, 1'b1, mac_dp_pkg::OP_MAC}, 4'd9);
      rd(mac_dp_pkg::IDX_FLAGS, 8'h84);
      issue('{1'b0, 2'd2, 1'b1, mac_dp_pkg::OP_CLEAR}, 4'd2);
      chk_m(40'h0);
      issue('{1'b0, 2'd2, 1'b1, mac_dp_pkg::OP_MAC}, 4'd9);
      rd(mac_dp_pkg::IDX_FLAGS, 8'h04);
      core_bus_model_i.xfer(1'b0, 8'h10, 32'h0, rdv, err);
      chk({7'h0, err, rdv}, {7'h0, 1'b1, 32'h0});
      complete_run();
   end
endmodule // test_mac_and_dual_pointer_unit
